// ### design/boot_ctl_end.sv
`default_nettype none
module boot_ctl_end
  import boot_link_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  boot_link_if.ctl         lnk,
  input  wire logic        start,
  input  wire logic [15:0] bit_cycles,
  input  wire logic        send_valid,
  input  wire logic [7:0]  send_data,
  input  wire logic        send_err,
  input  wire logic        send_ck,
  output logic             reply_valid,
  output logic      [7:0]  reply_data,
  output logic             link_up,
  output logic             link_dead
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {C_IDLE, C_SYNC, C_WAIT, C_UP, C_DEAD} ctl_state_e;

  typedef struct packed {
    ctl_state_e  st;
    logic [9:0]  sh;
    logic [3:0]  bitn;
    logic [15:0] bcnt;
    logic [15:0] bper;
    logic [31:0] tmo;
    logic [7:0]  sum;
    logic        line;
    logic        heard;
    logic        tx_v;
    logic [7:0]  tx_d;
    logic        tx_e;
    logic        rv;
    logic [7:0]  rd;
  } ctl_s;

  ctl_s r;
  ctl_s next_r;

  always_comb begin
    next_r = r;
    next_r.tx_v = 1'b0;
    next_r.tx_e = 1'b0;
    next_r.rv = 1'b0;
    unique case (r.st)
      C_IDLE: begin
        next_r.line = 1'b1;
        if (start) begin
          // 86H frame at chosen bit time
          next_r.st = C_SYNC;
          next_r.sh = SYNC_FRAME;
          next_r.bitn = 4'h0;
          next_r.bcnt = 16'h0000;
          next_r.bper = (bit_cycles == 16'h0000) ? 16'h0001 : bit_cycles;
          next_r.line = SYNC_FRAME[0];
        end
      end
      C_SYNC: begin
        next_r.bcnt = r.bcnt + 16'h0001;
        // early reply kept
        // the far end answers once it has timed the start run, before our stop bit
        if (lnk.d2c_valid) begin
          next_r.heard = 1'b1;
          next_r.rv = 1'b1;
          next_r.rd = lnk.d2c_data;
        end
        if (r.bcnt == r.bper - 16'h0001) begin
          next_r.bcnt = 16'h0000;
          if (r.bitn == SYNC_LAST) begin
            next_r.st = C_WAIT;
            next_r.tmo = 32'h0000_0000;
          end else begin
            next_r.bitn = r.bitn + 4'h1;
            next_r.sh = {1'b1, r.sh[9:1]};
            next_r.line = r.sh[1];
          end
        end
      end
      C_WAIT: begin
        next_r.tmo = r.tmo + 32'h0000_0001;
        if (r.heard) begin
          next_r.st = (r.rd == SYNC_BYTE) ? C_UP : C_DEAD;
        end else if (lnk.d2c_valid) begin
          next_r.st = (lnk.d2c_data == SYNC_BYTE) ? C_UP : C_DEAD;
          next_r.rv = 1'b1;
          next_r.rd = lnk.d2c_data;
        end else if (r.tmo == 32'(TIMEOUT_CYCLES - 1)) begin
          next_r.st = C_DEAD;
        end
      end
      C_UP: begin
        // command byte is the user's first send
        if (send_valid) begin
          next_r.tx_v = 1'b1;
          next_r.tx_d = send_data;
          next_r.tx_e = send_err;
          next_r.sum = r.sum + send_data;
        end else if (send_ck) begin
          next_r.tx_v = 1'b1;
          next_r.tx_d = 8'h00 - r.sum;
          next_r.sum = 8'h00;
        end
        if (lnk.d2c_valid) begin
          next_r.rv = 1'b1;
          next_r.rd = lnk.d2c_data;
          next_r.sum = 8'h00;
        end
      end
      C_DEAD: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
      r.line <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign lnk.sync_line = r.line;
  assign lnk.c2d_valid = r.tx_v;
  assign lnk.c2d_data  = r.tx_d;
  assign lnk.c2d_err   = r.tx_e;
  assign reply_valid   = r.rv;
  assign reply_data    = r.rd;
  assign link_up       = (r.st == C_UP);
  assign link_dead     = (r.st == C_DEAD);
endmodule
`default_nettype wire

// ### design/boot_dev_end.sv
`default_nettype none
// Function
// - erase clears flash and protection
// - erase needs no password
// - protect set arms both protections
// - sync 86H timed with reception off
// - unusable rate: halt, no reply
// - program baud, enable receive, send 86H
// - controller times out after 5 s
// - controller sends command third
// - receive error on command: x8H
// - ram command echoed, or x6H protected
// - unknown command: x1H
// - twelve password bytes compared to flash
// - controller appends two's complement checksum
// - receive error in password field: 18H
// - nonzero password field sum: 11H
// - password mismatch 11H, else 10H
// - address msb first, count high first
// - header: 18H error, 11H bad sum
// - load bytes outside user RAM are dropped
// - data stored from start address, count
// - data block answered 18H/11H/10H
// - on final 10H jump to start
module boot_dev_end
  import boot_link_pkg::*;
#(
  parameter int RAM_DEPTH = RAM_BYTES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  boot_link_if.dev         lnk,
  input  wire logic [95:0] flash_password,
  input  wire logic [11:0] ram_raddr,
  output logic      [7:0]  ram_rdata,
  output logic             rd_protect,
  output logic             wr_protect,
  output logic             receive_enable_bit,
  output logic      [15:0] baud_gen_control,
  output logic             baud_gen_fraction,
  output logic             boot_halted,
  output logic             erase_all,
  output logic             jump_valid,
  output logic      [31:0] jump_addr
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [3:0] {
    S_SYNC_IDLE, S_SYNC_LOW, S_ACK86, S_HALT, S_CMD, S_PWD, S_HDR, S_DATA, S_DCK, S_RUN
  } dev_state_e;
  typedef struct packed {
    dev_state_e  st;
    logic [16:0] lowcnt;
    logic [15:0] cnt;
    logic [7:0]  sum;
    logic        err;
    logic        pw_bad;
    logic [3:0]  hi;
    logic [7:0]  cmd;
    logic [31:0] addr;
    logic [15:0] len;
    logic        rx_en;
    logic [15:0] bctl;
    logic        bfrac;
    logic        rprot;
    logic        wprot;
    logic        halt;
    logic        tx_v;
    logic [7:0]  tx_d;
    logic        jmp;
    logic        ers;
    logic        we;
    logic [11:0] wa;
    logic [7:0]  wd;
  } dev_s;
  dev_s r;
  dev_s next_r;
  logic [7:0] mem [RAM_DEPTH];
  logic [7:0] rdata;
  function automatic logic known_cmd(input logic [7:0] c);
    return c == CMD_RAM || c == CMD_SUM || c == CMD_INFO || c == CMD_ERASE || c == CMD_PROT;
  endfunction
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic        rx;
    logic [7:0]  b;
    logic        e;
    logic [7:0]  s;
    logic [31:0] a;
    logic [31:0] off;
    rx = lnk.c2d_valid && r.rx_en;
    b = lnk.c2d_data;
    e = lnk.c2d_err;
    s = r.sum + b;
    a = r.addr + {16'h0000, r.cnt};
    off = a - RAM_LO;
    next_r = r;
    next_r.tx_v = 1'b0;
    next_r.jmp = 1'b0;
    next_r.ers = 1'b0;
    next_r.we = 1'b0;
    unique case (r.st)
      S_SYNC_IDLE: begin
        if (!lnk.sync_line) begin
          next_r.st = S_SYNC_LOW;
          next_r.lowcnt = 17'h00001;
        end
      end
      S_SYNC_LOW: begin
        // start bit plus bit 0 of 86H: low for two bit times
        if (!lnk.sync_line) begin
          if (r.lowcnt != '1) next_r.lowcnt = r.lowcnt + 17'h00001;
        end else if (r.lowcnt[16:1] >= BAUD_MIN_CYC && r.lowcnt != '1) begin
          next_r.bctl = r.lowcnt[16:1];
          next_r.bfrac = r.lowcnt[0];
          next_r.rx_en = 1'b1;
          next_r.st = S_ACK86;
        end else begin
          next_r.halt = 1'b1;
          next_r.st = S_HALT;
        end
      end
      S_ACK86: begin
        next_r.tx_v = 1'b1;
        next_r.tx_d = SYNC_BYTE;
        next_r.st = S_CMD;
      end
      S_HALT, S_RUN: ;
      S_CMD: begin
        if (rx) begin
          next_r.hi = b[7:4];
          next_r.cmd = b;
          next_r.tx_v = 1'b1;
          next_r.pw_bad = 1'b0;
          if (e) begin
            next_r.tx_d = {r.hi, ACK_COMM};
          end else if (!known_cmd(b)) begin
            next_r.tx_d = {r.hi, ACK_BAD};
          end else if (b == CMD_RAM && (r.rprot || r.wprot)) begin
            next_r.tx_d = {r.hi, ACK_PROT};
          end else begin
            next_r.tx_d = b;
            if (b == CMD_RAM || b == CMD_PROT) next_r.st = S_PWD;
            if (b == CMD_ERASE) begin
              next_r.ers = 1'b1;
              next_r.rprot = 1'b0;
              next_r.wprot = 1'b0;
            end
          end
        end
      end
      S_PWD: begin
        if (rx) begin
          next_r.sum = s;
          next_r.err = r.err | e;
          next_r.cnt = r.cnt + 16'h0001;
          if (r.cnt < PW_LEN && b != flash_password[{r.cnt[3:0], 3'b000} +: 8])
            next_r.pw_bad = 1'b1;
          if (r.cnt == PW_LEN) begin
            next_r.tx_v = 1'b1;
            next_r.st = S_CMD;
            if (r.err | e) next_r.tx_d = {r.hi, ACK_COMM};
            else if (s != 8'h00) next_r.tx_d = {r.hi, ACK_BAD};
            else if (r.pw_bad) next_r.tx_d = {r.hi, ACK_BAD};
            else begin
              next_r.tx_d = {r.hi, ACK_OK};
              if (r.cmd == CMD_PROT) begin
                next_r.rprot = 1'b1;
                next_r.wprot = 1'b1;
              end else begin
                next_r.st = S_HDR;
              end
            end
          end
        end
      end
      S_HDR: begin
        if (rx) begin
          next_r.sum = s;
          next_r.err = r.err | e;
          next_r.cnt = r.cnt + 16'h0001;
          if (r.cnt < 16'h0004) next_r.addr = {r.addr[23:0], b};
          else if (r.cnt < HDR_CK_IDX) next_r.len = {r.len[7:0], b};
          if (r.cnt == HDR_CK_IDX) begin
            next_r.tx_v = 1'b1;
            next_r.st = S_CMD;
            if (r.err | e) next_r.tx_d = {r.hi, ACK_COMM};
            else if (s != 8'h00) next_r.tx_d = {r.hi, ACK_BAD};
            else begin
              next_r.tx_d = {r.hi, ACK_OK};
              next_r.st = (r.len == 16'h0000) ? S_DCK : S_DATA;
            end
          end
        end
      end
      S_DATA: begin
        if (rx) begin
          next_r.sum = s;
          next_r.err = r.err | e;
          next_r.cnt = r.cnt + 16'h0001;
          // sequential store; outside user RAM is dropped
          if (a >= RAM_LO && a <= RAM_HI) begin
            next_r.we = 1'b1;
            next_r.wa = off[11:0];
            next_r.wd = b;
          end
          if (r.cnt == r.len - 16'h0001) next_r.st = S_DCK;
        end
      end
      S_DCK: begin
        if (rx) begin
          next_r.tx_v = 1'b1;
          next_r.st = S_CMD;
          // data checks, no jump on error
          if (r.err | e) next_r.tx_d = {r.hi, ACK_COMM};
          else if (s != 8'h00) next_r.tx_d = {r.hi, ACK_BAD};
          else begin
            next_r.tx_d = {r.hi, ACK_OK};
            next_r.jmp = 1'b1;
            next_r.st = S_RUN;
          end
        end
      end
    endcase
    // every reply opens a fresh field
    if (next_r.tx_v) {next_r.cnt, next_r.sum, next_r.err} = '0;
  end
  // ****************************************
  // registers and memory
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (r.we) mem[r.wa] <= r.wd;
    rdata <= mem[ram_raddr];
  end
  assign ram_rdata          = rdata;
  assign lnk.d2c_valid      = r.tx_v;
  assign lnk.d2c_data       = r.tx_d;
  assign rd_protect         = r.rprot;
  assign wr_protect         = r.wprot;
  assign receive_enable_bit = r.rx_en;
  assign baud_gen_control   = r.bctl;
  assign baud_gen_fraction  = r.bfrac;
  assign boot_halted        = r.halt;
  assign erase_all          = r.ers;
  assign jump_valid         = r.jmp;
  assign jump_addr          = r.addr;
endmodule
`default_nettype wire

// ### design/boot_link_if.sv
`default_nettype none
interface boot_link_if (
  input wire logic clk_sys
);
  logic       sync_line;
  logic       c2d_valid;
  logic [7:0] c2d_data;
  logic       c2d_err;
  logic       d2c_valid;
  logic [7:0] d2c_data;

  modport dev (
    input  sync_line,
    input  c2d_valid,
    input  c2d_data,
    input  c2d_err,
    output d2c_valid,
    output d2c_data
  );
  modport ctl (
    output sync_line,
    output c2d_valid,
    output c2d_data,
    output c2d_err,
    input  d2c_valid,
    input  d2c_data
  );
endinterface
`default_nettype wire

// ### design/boot_link_pkg.sv
`default_nettype none
package boot_link_pkg;
  // ****************************************
  // link bytes and commands
  // ****************************************
  localparam logic [7:0]  SYNC_BYTE  = 8'h86;
  localparam logic [7:0]  CMD_RAM    = 8'h10;
  localparam logic [7:0]  CMD_SUM    = 8'h20;
  localparam logic [7:0]  CMD_INFO   = 8'h30;
  localparam logic [7:0]  CMD_ERASE  = 8'h40;
  localparam logic [7:0]  CMD_PROT   = 8'h60;
  localparam logic [3:0]  ACK_OK     = 4'h0;
  localparam logic [3:0]  ACK_BAD    = 4'h1;
  localparam logic [3:0]  ACK_PROT   = 4'h6;
  localparam logic [3:0]  ACK_COMM   = 4'h8;
  // ****************************************
  // frame layout and memory map
  // ****************************************
  localparam logic [15:0] PW_LEN     = 16'h000c;
  localparam logic [15:0] HDR_CK_IDX = 16'h0006;
  localparam logic [23:0] PW_ADDR_LO = 24'h027ef4;
  localparam logic [23:0] PW_ADDR_HI = 24'h027eff;
  localparam logic [31:0] RAM_LO     = 32'h0000_1000;
  localparam logic [31:0] RAM_HI     = 32'h0000_1dff;
  localparam int          RAM_BYTES  = 3584;
  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_HZ      = 20_000_000;
  localparam int          TIMEOUT_S   = 5;
  localparam int          TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  localparam logic [15:0] BAUD_MIN_CYC = 16'h0004;
  localparam logic [9:0]  SYNC_FRAME  = {1'b1, SYNC_BYTE, 1'b0};
  localparam logic [3:0]  SYNC_LAST   = 4'h9;
endpackage
`default_nettype wire

// ### verification/boot_link_sva.sv
`default_nettype none
module boot_link_sva
  import boot_link_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       sync_line,
  input wire logic       c2d_valid,
  input wire logic [7:0] c2d_data,
  input wire logic       c2d_err,
  input wire logic       d2c_valid,
  input wire logic [7:0] d2c_data
);
  // ****************************************
  // link phase tracking
  // ****************************************
  logic       seen;
  logic       wait_cmd;
  logic       took_cmd;
  logic       field_err;
  logic [7:0] acc;
  logic [3:0] last_hi;
  logic       known;
  assign known = c2d_data inside {CMD_RAM, CMD_SUM, CMD_INFO, CMD_ERASE, CMD_PROT};
  // a 60h reply outside a command ends protect set, hence back to command wait
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seen      <= 1'b0;
      wait_cmd  <= 1'b0;
      took_cmd  <= 1'b0;
      field_err <= 1'b0;
      acc       <= 8'h00;
      last_hi   <= 4'h0;
    end else begin
      if (c2d_valid) begin
        took_cmd  <= wait_cmd;
        wait_cmd  <= 1'b0;
        acc       <= acc + c2d_data;
        field_err <= field_err | c2d_err;
        if (wait_cmd) last_hi <= c2d_data[7:4];
      end
      if (d2c_valid) begin
        seen      <= 1'b1;
        took_cmd  <= 1'b0;
        acc       <= 8'h00;
        field_err <= 1'b0;
        wait_cmd  <= took_cmd ? !(d2c_data inside {CMD_RAM, CMD_PROT})
                              : (!seen || d2c_data[3:0] != ACK_OK || d2c_data == CMD_PROT);
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_cmd;
    c2d_valid && wait_cmd && !c2d_err;
  endsequence
  property p_first_ack;
    d2c_valid && !seen |-> d2c_data == SYNC_BYTE;
  endproperty
  property p_quiet_link;
    c2d_valid |-> seen;
  endproperty
  property p_line_idle;
    c2d_valid |-> sync_line;
  endproperty
  property p_cmd_answer;
    c2d_valid && wait_cmd |=> d2c_valid ##1 !d2c_valid;
  endproperty
  property p_cmd_err;
    c2d_valid && wait_cmd && c2d_err |=> d2c_data == {$past(last_hi), ACK_COMM};
  endproperty
  property p_cmd_unknown;
    s_cmd ##0 !known |=> d2c_data == {$past(last_hi), ACK_BAD};
  endproperty
  property p_cmd_echo;
    s_cmd ##0 (known && c2d_data != CMD_RAM) |=> d2c_data == $past(c2d_data);
  endproperty
  property p_ram_cmd;
    s_cmd ##0 c2d_data == CMD_RAM |=>
      d2c_data == CMD_RAM || d2c_data == {$past(last_hi), ACK_PROT};
  endproperty
  property p_field_err;
    d2c_valid && seen && !took_cmd && field_err |-> d2c_data[3:0] == ACK_COMM;
  endproperty
  property p_field_ok;
    d2c_valid && seen && !took_cmd && d2c_data[3:0] == ACK_OK |-> acc == 8'h00 && !field_err;
  endproperty
  a_first_ack: assert property (p_first_ack) else $error("first reply not sync ack");
  a_quiet_link: assert property (p_quiet_link) else $error("byte before sync ack");
  a_line_idle: assert property (p_line_idle) else $error("byte during sync frame");
  a_cmd_answer: assert property (p_cmd_answer) else $error("command reply timing");
  a_cmd_err: assert property (p_cmd_err) else $error("command error reply");
  a_cmd_unknown: assert property (p_cmd_unknown) else $error("unknown command reply");
  a_cmd_echo: assert property (p_cmd_echo) else $error("command not echoed");
  a_ram_cmd: assert property (p_ram_cmd) else $error("ram command reply");
  a_field_err: assert property (p_field_err) else $error("receive error not flagged");
  a_field_ok: assert property (p_field_ok) else $error("ok reply on bad field");
endmodule
`default_nettype wire

// ### verification/testbench.sv
`default_nettype none
module testbench
  import boot_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // harness
  // ****************************************
  localparam logic [95:0] PW   = 96'h3c5a_9617_e2d4_7b08_c1f3_6e25;
  localparam logic [47:0] HDR  = 48'h0000_1004_0003;
  localparam logic [23:0] DATA = 24'hc3_5a_a5;
  logic        clk_sys, rst, start, send_valid, send_err, send_ck, reply_valid, link_up;
  logic        link_dead, rd_protect, wr_protect, rx_en, baud_frac, halted;
  logic        erase_all, jump_valid;
  logic [15:0] bit_cycles, baud_ctl;
  logic [7:0]  send_data, reply_data, ram_rdata;
  logic [11:0] ram_raddr;
  logic [31:0] jump_addr;
  int          n_errors, checks, n_erase, n_jump, n_reply, cyc;
  boot_link_if lnk (.clk_sys(clk_sys));
  boot_dev_end u_boot_dev_end (.clk_sys(clk_sys), .rst(rst), .lnk(lnk),
    .flash_password(PW), .ram_raddr(ram_raddr), .ram_rdata(ram_rdata),
    .rd_protect(rd_protect), .wr_protect(wr_protect), .receive_enable_bit(rx_en),
    .baud_gen_control(baud_ctl), .baud_gen_fraction(baud_frac), .boot_halted(halted),
    .erase_all(erase_all), .jump_valid(jump_valid), .jump_addr(jump_addr));
  // short timeout keeps the dead-link case quick
  boot_ctl_end #(.TIMEOUT_CYCLES(200)) u_boot_ctl_end (.clk_sys(clk_sys), .rst(rst),
    .lnk(lnk), .start(start), .bit_cycles(bit_cycles), .send_valid(send_valid),
    .send_data(send_data), .send_err(send_err), .send_ck(send_ck),
    .reply_valid(reply_valid), .reply_data(reply_data), .link_up(link_up),
    .link_dead(link_dead));
  boot_link_sva u_boot_link_sva (.clk_sys(clk_sys), .rst(rst), .sync_line(lnk.sync_line),
    .c2d_valid(lnk.c2d_valid), .c2d_data(lnk.c2d_data), .c2d_err(lnk.c2d_err),
    .d2c_valid(lnk.d2c_valid), .d2c_data(lnk.d2c_data));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (erase_all === 1'b1) n_erase++;
    if (jump_valid === 1'b1) n_jump++;
    if (reply_valid === 1'b1) n_reply++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic e);
    send_valid <= 1'b1;
    send_data  <= b;
    send_err   <= e;
    @(posedge clk_sys);
  endtask
  task automatic ck();
    send_valid <= 1'b0;
    send_err   <= 1'b0;
    send_ck    <= 1'b1;
    @(posedge clk_sys);
    send_ck <= 1'b0;
  endtask
  task automatic get(input logic [7:0] exp);
    int i;
    send_valid <= 1'b0;
    send_err   <= 1'b0;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (reply_valid !== 1'b1 && i < 400);
    chk("reply", exp, reply_data);
    @(posedge clk_sys);
  endtask
  task automatic cmd(input logic [7:0] b, input logic e, input logic [7:0] exp);
    put(b, e);
    get(exp);
  endtask
  // mode 1 bad byte, 2 bad checksum, 3 wrong password
  task automatic pw(input int m);
    for (int i = 0; i < 12; i++) put(PW[8*i +: 8] ^ {7'h00, m == 3 && i == 0}, m == 1 && i == 5);
    if (m == 2) put(8'h00, 1'b0);
    else ck();
  endtask
  // mode 1 header error, 2 data error, 3 data checksum, 0 clean load
  task automatic ram_load(input int m);
    cmd(CMD_RAM, 1'b0, CMD_RAM);
    pw(0);
    get(8'h10);
    for (int i = 0; i < 6; i++) put(HDR[8*(5-i) +: 8], m == 1 && i == 2);
    ck();
    get(m == 1 ? 8'h18 : 8'h10);
    if (m != 1) begin
      for (int i = 0; i < 3; i++) put(DATA[8*i +: 8], m == 2 && i == 1);
      if (m == 3) put(8'h00, 1'b0);
      else ck();
      get(m == 2 ? 8'h18 : (m == 3 ? 8'h11 : 8'h10));
    end
    chk("jumps", 32'(m == 0), n_jump);
    if (m == 0) begin
      chk("jump addr", HDR[47:16], jump_addr);
      for (int i = 0; i < 3; i++) begin
        ram_raddr <= 12'(4 + i);
        repeat (3) @(negedge clk_sys);
        chk("ram", DATA[8*i +: 8], ram_rdata);
        @(posedge clk_sys);
      end
    end
  endtask
  task automatic reset_dut();
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    n_reply = 0;
  endtask
  task automatic link(input logic [15:0] bits);
    bit_cycles <= bits;
    start      <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic scen_cmds();
    cmd(8'h55, 1'b0, 8'h01);
    cmd(8'h5a, 1'b1, 8'h58);
    cmd(CMD_SUM, 1'b0, CMD_SUM);
    cmd(CMD_INFO, 1'b0, CMD_INFO);
    cmd(CMD_ERASE, 1'b0, CMD_ERASE);
    chk("erase", 1, n_erase);
    cmd(8'h4b, 1'b1, 8'h48);
    for (int m = 1; m < 4; m++) begin
      cmd(CMD_RAM, 1'b0, CMD_RAM);
      pw(m);
      get(m == 1 ? 8'h18 : 8'h11);
    end
  endtask
  task automatic scen_protect();
    cmd(CMD_PROT, 1'b0, CMD_PROT);
    pw(3);
    get(8'h61);
    chk("rd protect", 0, rd_protect);
    cmd(CMD_PROT, 1'b0, CMD_PROT);
    pw(0);
    get(8'h60);
    chk("protect", 2'b11, {rd_protect, wr_protect});
    cmd(CMD_RAM, 1'b0, 8'h66);
    cmd(CMD_ERASE, 1'b0, CMD_ERASE);
    chk("protect", 0, {rd_protect, wr_protect});
  endtask
  initial begin
    {rst, start, send_valid, send_err, send_ck} = 5'b10000;
    {bit_cycles, send_data, ram_raddr} = '0;
    reset_dut();
    link(16'h0004);
    get(SYNC_BYTE);
    chk("rx enable", 1, rx_en);
    chk("baud", 32'h0004_0000, {baud_ctl, 15'h0, baud_frac});
    // the ack lands mid-frame; the link comes up after the stop bit
    repeat (40) @(posedge clk_sys);
    chk("link up", 1, link_up);
    scen_cmds();
    scen_protect();
    for (int m = 1; m < 4; m++) ram_load(m);
    ram_load(0);
    reset_dut();
    link(16'h0003);
    repeat (300) @(posedge clk_sys);
    chk("halted", 1, halted);
    chk("replies", 0, n_reply);
    chk("rx enable", 0, rx_en);
    chk("link dead", 1, link_dead);
    report_and_stop();
  end
endmodule
`default_nettype wire
